// ===== common/sar_consts.svh
// Constants of the converter control block: offsets, fields, resets, timing.
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define ADDR_OFFSET 4'h0
`define ADDR_RESULT 4'h4
`define ADDR_STATUS 4'h8
`define OFS_BITS 12
`define RES_BITS 15
`define FULL_SCALE 15'h3fff
`define ZERO_CODE 15'h0000
`define OFS_RESET 12'h000
`define ST_BUSY 0
`define ST_LIGHT 1
`define ST_DEEP 2
`define ST_READY 3
`define CLK_NS 50
`define LIGHT_WAKE_NS 100
`define DEEP_WAKE_US 200
`define LIGHT_WAKE_CYC ((`LIGHT_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define DEEP_WAKE_CYC ((`DEEP_WAKE_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== common/sar_pkg.sv
// Types of the converter control block.
package sar_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_END} conv_state_t;
  typedef enum logic [1:0] {PW_FULL, PW_LIGHT, PW_DEEP} power_mode_t;
endpackage : sar_pkg

// ===== hw/sar_adc_ctrl.sv
// Control logic of a 14-bit successive-approximation converter.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Overview of operation
// RULE_01 - Falling conversion start puts the sampler in hold and starts converting.
// RULE_02 - After the last trial bit the raw result stays in the SAR register.
// RULE_03 - At end of conversion the sampler goes back to tracking.
// RULE_04 - Result is straight binary, one step is reference over 16384.
// RULE_05 - Light sleep pin high gives light sleep, deep pin high deep sleep.
// RULE_06 - Light sleep powers everything down except the reference.
// RULE_07 - Host waits 100 ns after light sleep before starting a conversion.
// RULE_08 - Deep sleep powers everything down, the reference included.
// RULE_09 - Host waits 200 us after deep sleep before starting a conversion.
// RULE_10 - Clipping on with zero offset acts as a plain 14-bit converter.
// RULE_11 - With clipping on, bit fourteen flags input outside the nominal range.
// RULE_12 - A nonzero offset is added to the raw result at end of conversion.
// RULE_13 - With clipping on, the corrected result saturates to 0x0000..0x3fff.
// RULE_14 - Clipping is enabled only while the enable_a input is high.
// RULE_15 - Busy goes low after conversion start and stays low throughout.
// RULE_16 - Host writes offsets as 12-bit two's complement within +/-1310.
// RULE_17 - Clipping off gives the unsaturated corrected result on fifteen bits.
// ------------------------------------------------------------
`include "sar_consts.svh"

module sar_adc_ctrl #(
  parameter int SAR_BITS = 14,
  parameter int DEEP_WAKE_CYCLES = `DEEP_WAKE_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // Host control pins.
  input wire logic CONVERSION_START_N_IN,
  input wire logic LIGHT_SLEEP_PIN_IN,
  input wire logic DEEP_SLEEP_PIN_IN,
  input wire logic ENABLE_A_IN,
  // Analog front end.
  input wire logic COMP_IN,
  input wire logic ABOVE_FS_IN,
  input wire logic BELOW_ZS_IN,
  output logic HOLD_OUT,
  output logic [SAR_BITS-1:0] DAC_CODE_OUT,
  output logic REF_EN_OUT,
  output logic CORE_PWR_OUT,
  // Result and status.
  output logic BUSY_N_OUT,
  output logic [`RES_BITS-1:0] RESULT_OUT,
  // Register port.
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT
);
  import sar_pkg::*;

  // ------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------
  // Saturates a signed corrected sum into the 14-bit code range.
  function automatic logic [`RES_BITS-1:0] clamp_code(
    input logic signed [16:0] sum
  );
    if (sum < 17'sd0)
      clamp_code = `ZERO_CODE;
    else if (sum > 17'sd16383)
      clamp_code = `FULL_SCALE;
    else
      clamp_code = sum[`RES_BITS-1:0];
  endfunction : clamp_code

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  conv_state_t state_q, state_d;
  power_mode_t pmode_q;
  logic start_n_q;
  logic hold_q;
  logic busy_n_q;
  logic [SAR_BITS-1:0] sar_q, sar_d;
  logic [SAR_BITS-1:0] trial_q, trial_d;
  logic [SAR_BITS-1:0] dac_q;
  logic over_q;
  logic [`RES_BITS-1:0] result_q;
  logic [`OFS_BITS-1:0] offset_q;
  logic [12:0] wake_q;
  logic [31:0] rdata_q;
  logic ref_en_q;
  logic core_pwr_q;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  wire start_fall = start_n_q & ~CONVERSION_START_N_IN;
  wire asleep = DEEP_SLEEP_PIN_IN | LIGHT_SLEEP_PIN_IN;
  wire go = start_fall & ~asleep & (state_q == ST_IDLE);
  wire last_bit = trial_q[0];
  wire [SAR_BITS-1:0] kept = COMP_IN ? (sar_q | trial_q) : sar_q;
  wire signed [16:0] raw_s = {3'b000, sar_q};
  wire signed [16:0] ofs_s = {{5{offset_q[`OFS_BITS-1]}}, offset_q};
  wire signed [16:0] sum_s = raw_s + ofs_s;
  wire [`RES_BITS-1:0] clipped = clamp_code(sum_s);
  wire [`RES_BITS-1:0] corrected = ENABLE_A_IN ? clipped : sum_s[`RES_BITS-1:0];
  wire wr_ofs = WR_IN & (ADDR_IN == `ADDR_OFFSET);
  wire wake_done = (wake_q == 13'h0000);
  wire [31:0] status_word = {28'h0000000, wake_done, pmode_q == PW_DEEP,
    pmode_q == PW_LIGHT, ~busy_n_q};
  wire [31:0] rd_mux = (ADDR_IN == `ADDR_OFFSET) ? {20'h00000, offset_q} :
    (ADDR_IN == `ADDR_RESULT) ? {17'h00000, result_q} :
    (ADDR_IN == `ADDR_STATUS) ? status_word : 32'h00000000;
  wire power_mode_t pmode_d = DEEP_SLEEP_PIN_IN ? PW_DEEP :
    LIGHT_SLEEP_PIN_IN ? PW_LIGHT : PW_FULL; // RULE_05
  wire [12:0] wake_load = (pmode_q == PW_DEEP) ?
    13'(DEEP_WAKE_CYCLES) : 13'(`LIGHT_WAKE_CYC);

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    sar_d = sar_q;
    trial_d = trial_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (go) // RULE_01
        begin
          state_d = ST_CONV;
          sar_d = '0;
          trial_d = {1'b1, {(SAR_BITS-1){1'b0}}};
        end
      end
      ST_CONV:
      begin
        sar_d = kept;
        trial_d = trial_q >> 1;
        if (last_bit)
          state_d = ST_END; // RULE_02
      end
      ST_END:
      begin
        state_d = ST_IDLE;
        trial_d = '0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q <= ST_IDLE;
      sar_q <= '0;
      trial_q <= '0;
      dac_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      sar_q <= sar_d;
      trial_q <= trial_d;
      dac_q <= sar_d | trial_d;
    end
  end

  // Edge detector on the start pin; reset to idle-high, so a pin already low at
  // release is taken as a falling edge in the first cycle after reset.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      start_n_q <= 1'b1;
    else
      start_n_q <= CONVERSION_START_N_IN;
  end

  // ------------------------------------------------------------
  // Sampler, busy and out-of-range capture
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      hold_q <= 1'b0;
      busy_n_q <= 1'b1;
      over_q <= 1'b0;
    end
    else if (go)
    begin
      hold_q <= 1'b1; // RULE_01
      busy_n_q <= 1'b0; // RULE_15
      over_q <= ABOVE_FS_IN | BELOW_ZS_IN;
    end
    else if (state_q == ST_END)
    begin
      hold_q <= 1'b0; // RULE_03
      busy_n_q <= 1'b1; // RULE_15
    end
  end

  // ------------------------------------------------------------
  // Result formatting
  // ------------------------------------------------------------
  // The offset in force at the end of conversion is applied, so a write
  // landing mid-conversion affects that result; hosts write between them.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      result_q <= `ZERO_CODE;
    else if (state_q == ST_END)
    begin
      if (ENABLE_A_IN) // RULE_14
        result_q <= {over_q, clipped[SAR_BITS-1:0]}; // RULE_10 RULE_11 RULE_13
      else
        result_q <= corrected; // RULE_12 RULE_17
    end
  end

  // ------------------------------------------------------------
  // Power control
  // ------------------------------------------------------------
  // The wake counter only reports readiness; spacing starts after a wake
  // is the host's duty, the block converts whatever is presented.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pmode_q <= PW_FULL;
      ref_en_q <= 1'b1;
      core_pwr_q <= 1'b1;
      wake_q <= '0;
    end
    else
    begin
      pmode_q <= pmode_d;
      ref_en_q <= ~DEEP_SLEEP_PIN_IN; // RULE_06 RULE_08
      core_pwr_q <= ~asleep; // RULE_06
      if (asleep)
        wake_q <= '0;
      else if (pmode_q != PW_FULL)
        wake_q <= wake_load; // RULE_07 RULE_09
      else if (!wake_done)
        wake_q <= wake_q - 13'h0001;
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      offset_q <= `OFS_RESET;
    else if (wr_ofs)
      offset_q <= WDATA_IN[`OFS_BITS-1:0]; // RULE_16
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      rdata_q <= '0;
    else if (RD_IN)
      rdata_q <= rd_mux;
    else
      rdata_q <= '0;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign HOLD_OUT = hold_q;
  assign DAC_CODE_OUT = dac_q; // RULE_04
  assign REF_EN_OUT = ref_en_q;
  assign CORE_PWR_OUT = core_pwr_q;
  assign BUSY_N_OUT = busy_n_q;
  assign RESULT_OUT = result_q;
  assign RDATA_OUT = rdata_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  property p_start_holds;
    go |=> HOLD_OUT && !BUSY_N_OUT;
  endproperty
  a_start_holds: assert property (p_start_holds) else $error("no hold on start"); // RULE_01

  property p_conv_len;
    go |=> !BUSY_N_OUT [*8] ##1 !BUSY_N_OUT [*7] ##1 BUSY_N_OUT;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("busy length wrong"); // RULE_15

  property p_track_end;
    $rose(BUSY_N_OUT) |-> !HOLD_OUT && $fell(HOLD_OUT);
  endproperty
  a_track_end: assert property (p_track_end) else $error("no track at end"); // RULE_03

  property p_sar_kept;
    state_q == ST_END |=> $stable(sar_q);
  endproperty
  a_sar_kept: assert property (p_sar_kept) else $error("raw lost"); // RULE_02

  property p_enable_a_range;
    ENABLE_A_IN && state_q == ST_END |=> RESULT_OUT[SAR_BITS-1:0] ==
      ($past(sum_s) < 17'sd0 ? 14'h0000 :
      ($past(sum_s) > 17'sd16383 ? 14'h3fff : $past(sum_s[SAR_BITS-1:0])));
  endproperty
  a_enable_a_range: assert property (p_enable_a_range) else $error("enable_a wrong"); // RULE_13

  property p_ovr_flag;
    ENABLE_A_IN && state_q == ST_END |=> RESULT_OUT[`RES_BITS-1] == $past(over_q);
  endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("overrange bit wrong"); // RULE_11

  property p_plain_zero;
    ENABLE_A_IN && offset_q == 12'h000 && state_q == ST_END
      |=> RESULT_OUT[SAR_BITS-1:0] == $past(sar_q);
  endproperty
  a_plain_zero: assert property (p_plain_zero) else $error("zero offset changed code"); // RULE_10

  property p_noclip;
    !ENABLE_A_IN && state_q == ST_END |=> RESULT_OUT == $past(sum_s[`RES_BITS-1:0]);
  endproperty
  a_noclip: assert property (p_noclip) else $error("unclipped sum wrong"); // RULE_12

  property p_deep_off;
    DEEP_SLEEP_PIN_IN |=> !REF_EN_OUT && !CORE_PWR_OUT;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep not off"); // RULE_08

  property p_light_ref;
    LIGHT_SLEEP_PIN_IN && !DEEP_SLEEP_PIN_IN |=> REF_EN_OUT && !CORE_PWR_OUT;
  endproperty
  a_light_ref: assert property (p_light_ref) else $error("light sleep wrong"); // RULE_06

  c_conv: cover property (go ##[14:16] $rose(BUSY_N_OUT));
  c_enable_a_hi: cover property (ENABLE_A_IN && state_q == ST_END && sum_s > 17'sd16383);
  c_noclip_hi: cover property (!ENABLE_A_IN && state_q == ST_END && sum_s > 17'sd16383);
  c_deep_wake: cover property ($fell(DEEP_SLEEP_PIN_IN) ##1 !wake_done);

endmodule : sar_adc_ctrl

// ===== verification/sar_front_model.sv
// Behavioural analog front end: track/hold sampler and comparator.
`timescale 1ns/1ps
module sar_front_model (
  // Clock.
  input wire logic clk_in,
  // Converter side.
  input wire logic hold_in,
  input wire logic [13:0] code_in,
  input wire logic signed [31:0] vin_in,
  output logic comp_out,
  output logic above_out,
  output logic below_out
);
  int held_q = 0;
  // The sampler follows the input only while tracking, so a late input change is not seen.
  always @(posedge clk_in)
    if (!hold_in)
      held_q <= vin_in;
  // One code step is one unit of the input value.
  assign comp_out = (hold_in ? held_q : vin_in) >= int'(code_in);
  assign above_out = vin_in > 16383;
  assign below_out = vin_in < 0;
endmodule : sar_front_model

// ===== verification/sar_adc_conversion_offset_power_test.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
module sar_adc_conversion_offset_power_test;
  import sar_pkg::*;
  localparam int WAKE = 4;
  logic clk = 0, rst_n = 0, cs_n = 1, lt = 0, dp = 0, clp = 0, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] d;
  wire comp, above, below, hold, ref_en, core_pwr, busy_n;
  wire [13:0] dac;
  wire [14:0] res;
  wire [31:0] rdata;
  int vin = 0, num_errors = 0, num_checks = 0, ofs = 0, i;
  int cv[6] = '{0, 16383, -300, 17000, 5000, 16000};
  int co[6] = '{0, 0, 0, 0, -1310, 1310};
  logic cc[6] = '{1, 1, 1, 1, 1, 0};
  always #25 clk = ~clk;
  sar_adc_ctrl #(.DEEP_WAKE_CYCLES(WAKE)) sar_adc_ctrl_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .CONVERSION_START_N_IN(cs_n), .LIGHT_SLEEP_PIN_IN(lt), .DEEP_SLEEP_PIN_IN(dp), .ENABLE_A_IN(clp),
    .COMP_IN(comp), .ABOVE_FS_IN(above), .BELOW_ZS_IN(below), .HOLD_OUT(hold), .DAC_CODE_OUT(dac),
    .REF_EN_OUT(ref_en), .CORE_PWR_OUT(core_pwr), .BUSY_N_OUT(busy_n), .RESULT_OUT(res),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata));
  sar_front_model sar_front_model_inst (.clk_in(clk), .hold_in(hold), .code_in(dac), .vin_in(vin),
    .comp_out(comp), .above_out(above), .below_out(below));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task chk15(input logic [14:0] g, input logic [14:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk15
  task chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk32
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  function automatic logic [14:0] exp_res(input int v, input int o, input logic c);
    int raw;
    int s;
    raw = v < 0 ? 0 : (v > 16383 ? 16383 : v);
    s = raw + o;
    if (c)
      return {v < 0 || v > 16383, s < 0 ? 14'h0000 : (s > 16383 ? 14'h3fff : 14'(s))};
    return 15'(s);
  endfunction : exp_res
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task set_ofs(input int o);
    ofs = o;
    reg_wr(4'h0, 32'(o) & 32'h0000_0fff);
    reg_rd(4'h0);
    chk32(d, 32'(o) & 32'h0000_0fff);
  endtask : set_ofs
  task conv(input int v, input logic c);
    int n;
    @(posedge clk);
    vin <= v;
    clp <= c;
    cs_n <= 1'b0;
    n = 0;
    while (busy_n !== 1'b0)
    begin
      cyc(1);
      n++;
      if (n > 4)
      begin
        num_errors++;
        results();
      end
    end
    cs_n <= 1'b1;
    chk32(32'(hold), 32'h1);
    n = 0;
    while (busy_n === 1'b0 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk32(n, 32'd15);
    chk32(32'(hold), 32'h0);
    chk15(res, exp_res(v, ofs, c));
    reg_rd(4'h4);
    chk32(d, 32'(exp_res(v, ofs, c)));
  endtask : conv
  task sleep(input logic l, input logic p, input logic [1:0] pw);
    @(posedge clk);
    lt <= l;
    dp <= p;
    cs_n <= 1'b0;
    cyc(3);
    chk32(32'({ref_en, core_pwr}), 32'(pw));
    chk32(32'(busy_n), 32'h1);
    reg_rd(4'h8);
    chk32(d & 32'h6, 32'({p, l & ~p, 1'b0}));
    cs_n <= 1'b1;
    lt <= 1'b0;
    dp <= 1'b0;
    cyc(p ? WAKE + 2 : 3);
    reg_rd(4'h8);
    chk32(d & 32'hf, 32'h8);
  endtask : sleep
  initial
  begin
    void'($urandom(32'h10ed));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      set_ofs(co[i]);
      conv(cv[i], cc[i]);
    end
    for (i = 0; i < 30; i++)
    begin
      set_ofs(int'($urandom_range(2620)) - 1310);
      conv(int'($urandom_range(19200)) - 1400, 1'($urandom_range(1)));
    end
    sleep(1'b1, 1'b0, 2'b10);
    sleep(1'b0, 1'b1, 2'b00);
    sleep(1'b1, 1'b1, 2'b00);
    conv(8191, 1'b1);
    reg_wr(4'h4, 32'h0000_1234);
    reg_rd(4'h4);
    chk32(d, 32'(exp_res(8191, ofs, 1'b1)));
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    chk15(res, 15'h0000);
    chk32(32'({hold, busy_n, ref_en, core_pwr}), 32'h7);
    rst_n <= 1'b1;
    reg_rd(4'h0);
    chk32(d, 32'h0);
    reg_rd(4'hc);
    chk32(d, 32'h0);
    results();
  end
endmodule : sar_adc_conversion_offset_power_test
